// >>> design/jhe_category.v
/*
 Magnitude category and appended integer field of a signed difference.
 Assumes a 17-bit two's complement input; purely combinational.
*/
`timescale 1ns/100ps
module jhe_category
(
   input  wire [16:0] value_i,
   output reg  [4:0]  category_o,
   output reg  [15:0] field_o
);
   reg [16:0] mag;
   reg [16:0] adj;
   integer    k;

   // Highest set bit of the magnitude gives the category
   always @*
   begin
      mag = value_i[16] ? (~value_i + 17'h00001) : value_i;
      adj = value_i[16] ? (value_i - 17'h00001) : value_i; // RULE_03
      category_o = 5'h00;
      for (k = 0; k < 17; k = k + 1)
      begin
         if (mag[k])
            category_o = k[4:0] + 5'h01; // RULE_01
      end
      field_o = adj[15:0] & ~(16'hFFFF << category_o); // RULE_03
   end
endmodule // jhe_category

// >>> design/jhe_entropy_coder.v
/*
 Huffman entropy coder for baseline DCT blocks and lossless DPCM samples,
 plus the lossless reconstruction adder of the decoding direction.
 Assumes an upstream that presents one coefficient or sample per handshake
 and a downstream bit packer that takes one bit per handshake. Code tables
 are loaded over the table port before use; they are not reset.
*/
`timescale 1ns/100ps
`include "jhe_regs.vh"
module jhe_entropy_coder
#(
   parameter NCOMP = 4,
   parameter CW    = 2
)
(
   input  wire                 clock_i,
   input  wire                 arst_n_i,
   // Scan control
   input  wire                 scan_start_i,
   input  wire                 restart_i,
   input  wire                 hierarchical_i,
   input  wire [4:0]           precision_i,
   input  wire [3*NCOMP-1:0]   comp_predictor_i,
   input  wire [4*NCOMP-1:0]   comp_point_shift_i,
   input  wire [NCOMP-1:0]     comp_dc_table_i,
   input  wire [NCOMP-1:0]     comp_ac_table_i,
   // Table load port
   input  wire                 tbl_we_i,
   input  wire                 tbl_ac_i,
   input  wire [8:0]           tbl_addr_i,
   input  wire [15:0]          tbl_code_i,
   input  wire [4:0]           tbl_len_i,
   // Symbol input
   input  wire                 in_valid_i,
   output wire                 in_ready_o,
   input  wire                 in_mode_i,
   input  wire [CW-1:0]        in_comp_i,
   input  wire                 in_first_i,
   input  wire                 in_last_i,
   input  wire [15:0]          in_value_i,
   input  wire [15:0]          in_left_i,
   input  wire [15:0]          in_above_i,
   input  wire [15:0]          in_upleft_i,
   // Serial bitstream output
   output wire                 bit_valid_o,
   output wire                 bit_o,
   input  wire                 bit_ready_i,
   output reg                  err_o,
   // Lossless reconstruction
   input  wire                 rec_valid_i,
   input  wire [CW-1:0]        rec_comp_i,
   input  wire [15:0]          rec_diff_i,
   input  wire [15:0]          rec_left_i,
   input  wire [15:0]          rec_above_i,
   input  wire [15:0]          rec_upleft_i,
   output reg                  rec_valid_o,
   output reg  [15:0]          rec_sample_o
);
   localparam ST_IDLE  = 1'b0;
   localparam ST_SHIFT = 1'b1;

   reg  [1:0]  rst_sync;
   wire        rst_n = rst_sync[1];
   reg         state;
   reg  [31:0] sh_word;
   reg  [5:0]  sh_left;
   reg  [3:0]  run;
   reg  [CW-1:0] blk_comp;
   reg  [15:0] prev_dc [0:NCOMP-1];
   // Code tables: entry is {length, code}, indexed by table set and symbol
   reg  [20:0] dc_mem [0:63];
   reg  [20:0] ac_mem [0:511];

   // Reset release through two flops so every flop leaves reset together
   always @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         rst_sync <= 2'h0;
      else
         rst_sync <= {rst_sync[0], 1'b1};
   end

   // Tables are plain memories; software-free loading by upstream logic
   always @(posedge clock_i)
   begin
      if (tbl_we_i && !tbl_ac_i)
         dc_mem[tbl_addr_i[5:0]] <= {tbl_len_i, tbl_code_i};
      if (tbl_we_i && tbl_ac_i)
         ac_mem[tbl_addr_i] <= {tbl_len_i, tbl_code_i};
   end

   wire accept = in_valid_i && in_ready_o;
   wire lossless = (in_mode_i == `JHE_MODE_LOSSLESS);
   wire ac_term = !lossless && !in_first_i;
   wire clear_dc = scan_start_i || restart_i;

   // Component is latched at the DC term so a whole block stays one unit
   wire [CW-1:0] cur_comp = ac_term ? blk_comp : in_comp_i; // RULE_22 RULE_12
   wire [2:0] sel = comp_predictor_i[cur_comp*3 +: 3];      // RULE_13
   wire [3:0] pshift = lossless ? comp_point_shift_i[cur_comp*4 +: 4] : 4'h0; // RULE_21
   wire       dc_tab = comp_dc_table_i[cur_comp];
   wire       ac_tab = comp_ac_table_i[cur_comp];

   // Lossless: mask to precision, then scale down by the point shift
   wire [16:0] pmask_n = 17'h1FFFF << precision_i;
   wire [15:0] pmask = ~pmask_n[15:0]; // RULE_10
   wire [15:0] x_s = (in_value_i & pmask) >> pshift;   // RULE_20
   wire [15:0] a_s = (in_left_i & pmask) >> pshift;    // RULE_20
   wire [15:0] b_s = (in_above_i & pmask) >> pshift;   // RULE_20
   wire [15:0] c_s = (in_upleft_i & pmask) >> pshift;  // RULE_20
   wire [15:0] pred;
   wire [15:0] ll_diff = x_s - pred; // RULE_17

   jhe_predictor u_enc_pred
   (
      .select_i (sel),
      .left_i   (a_s),
      .above_i  (b_s),
      .upleft_i (c_s),
      .pred_o   (pred)
   );

   // Previous DC is forced to zero in the cycle the scan or interval opens
   wire [15:0] dc_ref = clear_dc ? `JHE_DC_RESET : prev_dc[cur_comp];
   wire [16:0] dc_diff = {in_value_i[15], in_value_i} - {dc_ref[15], dc_ref}; // RULE_23
   wire [16:0] cat_in = lossless ? {ll_diff[15], ll_diff} :
                        (in_first_i ? dc_diff : {in_value_i[15], in_value_i});
   wire [4:0]  cat;
   wire [15:0] field;

   // One categoriser serves DC, AC and lossless differences alike
   jhe_category u_cat
   (
      .value_i    (cat_in),   // RULE_05 RULE_19
      .category_o (cat),
      .field_o    (field)
   );

   wire ac_zero = (in_value_i == 16'h0000);
   wire [7:0] ac_idx = (ac_zero && in_last_i) ? `JHE_EOB_INDEX :  // RULE_06
                       (ac_zero ? `JHE_ZRL_INDEX : {run, cat[3:0]}); // RULE_04
   wire [20:0] dc_ent = dc_mem[{dc_tab, cat}];                     // RULE_02
   wire [20:0] ac_ent = ac_mem[{ac_tab, ac_idx}];

   // Error screening: bad selection, bad precision, oversize category
   wire sel_bad  = lossless && (sel == `JHE_PRED_NONE) && !hierarchical_i; // RULE_15
   wire prec_bad = lossless && ((precision_i < `JHE_MIN_PREC) ||
                   (precision_i > `JHE_MAX_PREC));                          // RULE_10
   wire cat_bad  = !lossless && ((in_first_i && (cat > `JHE_DCT_MAX_CAT)) ||
                   (!in_first_i && cat[4]));                                // RULE_01
   wire bad = sel_bad || prec_bad || cat_bad;

   reg [15:0] j_code;
   reg [4:0]  j_clen;
   reg [4:0]  j_vlen;
   reg [3:0]  next_run;

   // Choose the symbol that this input produces, if any
   always @*
   begin
      j_code = dc_ent[15:0];
      j_clen = dc_ent[20:16];
      j_vlen = (cat == `JHE_LL_FULL_CAT) ? 5'h00 : cat; // RULE_19
      next_run = 4'h0;
      if (ac_term)
      begin
         j_code = ac_ent[15:0];
         j_clen = ac_ent[20:16];
         if (ac_zero)
         begin
            j_vlen = 5'h00;
            if (in_last_i)
               next_run = 4'h0;                          // RULE_09
            else if (run != `JHE_RUN_LIMIT)
            begin
               next_run = run + 4'h1;                    // RULE_07
               j_clen = 5'h00;
            end
         end
      end
      if (bad)
      begin
         j_clen = 5'h00;
         j_vlen = 5'h00;
      end
   end

   // Code then field in one word, justified to the top for MSB-first exit
   wire [5:0]  j_total = {1'b0, j_clen} + {1'b0, j_vlen};
   wire [31:0] j_word = ({16'h0000, j_code} << j_vlen) |
                        {16'h0000, field & ~(16'hFFFF << j_vlen)};
   wire [5:0]  j_pad = 6'h20 - j_total;

   // Emission: at most one symbol per accepted input, bits leave from bit 31
   always @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state   <= ST_IDLE;
         sh_word <= 32'h00000000;
         sh_left <= 6'h00;
         err_o   <= 1'b0;
      end
      else
      begin
         err_o <= accept && bad;
         case (state)
            ST_IDLE:
            begin
               if (accept && (j_total != 6'h00))
               begin
                  sh_word <= j_word << j_pad;                 // RULE_26
                  sh_left <= j_total;
                  state   <= ST_SHIFT;
               end
            end
            ST_SHIFT:
            begin
               if (bit_ready_i)
               begin
                  sh_word <= {sh_word[30:0], 1'b0};           // RULE_26
                  sh_left <= sh_left - 6'h01;
                  if (sh_left == 6'h01)
                     state <= ST_IDLE;
               end
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   // Input is held off while a symbol drains, so order is kept end to end
   assign in_ready_o  = (state == ST_IDLE); // RULE_24
   assign bit_valid_o = (state == ST_SHIFT);
   assign bit_o       = sh_word[31];

   // Zero run and block component belong to the block in progress
   always @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         run      <= 4'h0;
         blk_comp <= {CW{1'b0}};
      end
      else if (accept && !lossless)
      begin
         if (in_first_i)
         begin
            run      <= 4'h0;
            blk_comp <= in_comp_i;                           // RULE_22
         end
         else
            run <= next_run;                                 // RULE_07 RULE_08
      end
   end

   // Per-component previous DC; a new DC term wins over a same-cycle clear
   genvar g;
   generate
      for (g = 0; g < NCOMP; g = g + 1)
      begin : g_dc
         always @(posedge clock_i or negedge rst_n)
         begin
            if (!rst_n)
               prev_dc[g] <= `JHE_DC_RESET;
            else if (accept && !lossless && in_first_i && !cat_bad &&
                     (in_comp_i == g))
               prev_dc[g] <= in_value_i;                     // RULE_23 RULE_13
            else if (clear_dc)
               prev_dc[g] <= `JHE_DC_RESET;                  // RULE_25
         end
      end
   endgenerate

   // Decoding direction: neighbours come in the scaled-down domain
   wire [2:0]  rsel = comp_predictor_i[rec_comp_i*3 +: 3];
   wire [3:0]  rshift = comp_point_shift_i[rec_comp_i*4 +: 4];
   wire [15:0] rpred;
   wire [15:0] rsum = rpred + rec_diff_i; // RULE_18

   jhe_predictor u_dec_pred
   (
      .select_i (rsel),
      .left_i   (rec_left_i),
      .above_i  (rec_above_i),
      .upleft_i (rec_upleft_i),
      .pred_o   (rpred)
   );

   // Rescale to the input range; one cycle of latency
   always @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rec_valid_o  <= 1'b0;
         rec_sample_o <= 16'h0000;
      end
      else
      begin
         rec_valid_o <= rec_valid_i;
         if (rec_valid_i)
            rec_sample_o <= rsum << rshift;                  // RULE_20
      end
   end

   // Only Huffman tables exist here; there is no arithmetic coder
   // RULE_11
endmodule // jhe_entropy_coder

// >>> design/jhe_predictor.v
/*
 Lossless spatial predictor over left, above and upper-left neighbours.
 Assumes unsigned samples of at most 16 bits; purely combinational.
*/
`timescale 1ns/100ps
`include "jhe_regs.vh"
module jhe_predictor
(
   input  wire [2:0]  select_i,
   input  wire [15:0] left_i,
   input  wire [15:0] above_i,
   input  wire [15:0] upleft_i,
   output reg  [15:0] pred_o
);
   wire signed [17:0] a = {2'h0, left_i};
   wire signed [17:0] b = {2'h0, above_i};
   wire signed [17:0] c = {2'h0, upleft_i};
   reg  signed [17:0] p;

   // Wide signed math, then wrap to 16 bits as the modulo arithmetic wants
   always @*
   begin
      case (select_i) // RULE_14
         `JHE_PRED_LEFT:  p = a;
         `JHE_PRED_ABOVE: p = b;
         `JHE_PRED_DIAG:  p = c;
         `JHE_PRED_PLANE: p = a + b - c;
         `JHE_PRED_LHALF: p = a + ((b - c) >>> 1); // RULE_16
         `JHE_PRED_AHALF: p = b + ((a - c) >>> 1); // RULE_16
         `JHE_PRED_MEAN:  p = (a + b) >>> 1;       // RULE_16
         default:         p = 18'h00000;           // RULE_15
      endcase
      pred_o = p[15:0];
   end
endmodule // jhe_predictor

// >>> design/jhe_regs.vh
/*
 Constants of the entropy coder: categories, table indices, predictor codes.
 Assumes inclusion by the coder and predictor design files; definitions only.
*/
// What this block does
// (RULE_01) Category is significant-bit count, zero to twelve; AC terms of category thirteen to fifteen are still coded
// (RULE_02) DC: table code for category, then field
// (RULE_03) Field: low bits of value, minus one if negative
// (RULE_04) AC index: run high nibble, category low
// (RULE_05) AC category uses the DC categorisation
// (RULE_06) Category-zero AC column holds only control codes
// (RULE_07) Run above fifteen emits sixteen-zero code
// (RULE_08) Nonzero AC: run plus category code, field
// (RULE_09) Trailing zero coefficient ends with end-of-block code
// (RULE_10) Lossless precision two through sixteen bits
// (RULE_11) Lossless coding uses Huffman codes only
// (RULE_12) Interleaved and non-interleaved component order both work
// (RULE_13) Each component has its own prediction state
// (RULE_14) Selections one to seven map to predictor forms
// (RULE_15) Selection zero only in hierarchical differential mode
// (RULE_16) Halving is arithmetic right shift
// (RULE_17) Encoder difference taken modulo 65536
// (RULE_18) Decoder sum taken modulo 65536
// (RULE_19) Lossless differences use seventeen-entry category scheme
// (RULE_20) Point shift divides input, multiplies decoder output
// (RULE_21) Point shift never used in DCT path
// (RULE_22) DCT interleave unit is one 8x8 block
// (RULE_23) DC difference against previous block, same component
// (RULE_24) DC first, then AC in zig-zag order
// (RULE_25) Previous DC cleared at scan and restart
// (RULE_26) Codes and fields leave most significant first
`ifndef JHE_REGS_VH
`define JHE_REGS_VH
`define JHE_DCT_MAX_CAT   5'h0C
`define JHE_LL_FULL_CAT   5'h10
`define JHE_MIN_PREC      5'h02
`define JHE_MAX_PREC      5'h10
`define JHE_RUN_LIMIT     4'hF
`define JHE_EOB_INDEX     8'h00
`define JHE_ZRL_INDEX     8'hF0
`define JHE_DC_RESET      16'h0000
`define JHE_PRED_NONE     3'h0
`define JHE_PRED_LEFT     3'h1
`define JHE_PRED_ABOVE    3'h2
`define JHE_PRED_DIAG     3'h3
`define JHE_PRED_PLANE    3'h4
`define JHE_PRED_LHALF    3'h5
`define JHE_PRED_AHALF    3'h6
`define JHE_PRED_MEAN     3'h7
`define JHE_MODE_DCT      1'b0
`define JHE_MODE_LOSSLESS 1'b1
`endif

// >>> dv/jhe_coder_checker.sv
/*
 Port-level properties of the entropy coder.
 Assumes binding to the coder top; one clock, asynchronous active-low reset.
*/
`timescale 1ns/100ps
module jhe_coder_checker
#(
   parameter NCOMP = 4,
   parameter CW    = 2
)
(
   input wire               clock_i,
   input wire               arst_n_i,
   input wire               hierarchical_i,
   input wire [4:0]         precision_i,
   input wire [3*NCOMP-1:0] comp_predictor_i,
   input wire [4*NCOMP-1:0] comp_point_shift_i,
   input wire               in_valid_i,
   input wire               in_ready_o,
   input wire               in_mode_i,
   input wire [CW-1:0]      in_comp_i,
   input wire               bit_valid_o,
   input wire               bit_o,
   input wire               bit_ready_i,
   input wire               err_o,
   input wire               rec_valid_i,
   input wire [CW-1:0]      rec_comp_i,
   input wire [15:0]        rec_diff_i,
   input wire [15:0]        rec_left_i,
   input wire               rec_valid_o,
   input wire [15:0]        rec_sample_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!arst_n_i);
   wire       acc  = in_valid_i && in_ready_o;
   wire [2:0] sel  = comp_predictor_i[3*in_comp_i +: 3];
   wire [2:0] rsel = comp_predictor_i[3*rec_comp_i +: 3];
   wire [3:0] rsh  = comp_point_shift_i[4*rec_comp_i +: 4];
   reg  [15:0] rec_sum;
   // Left-predictor sum one cycle back, for the reconstruction check
   always @(posedge clock_i) rec_sum <= rec_left_i + rec_diff_i;

   AST_SHIFT_BUSY: assert property (bit_valid_o |-> !in_ready_o)
      else $error("input ready while bits pending");
   AST_BIT_HOLD: assert property (bit_valid_o && !bit_ready_i |=> bit_valid_o && $stable(bit_o))
      else $error("stalled bit changed");
   AST_REJ_SEL0: assert property (acc && in_mode_i && !hierarchical_i && sel == 3'h0 |=> err_o)
      else $error("selection zero not refused");
   AST_REJ_PREC: assert property (acc && in_mode_i && (precision_i < 5'h02 || precision_i > 5'h10) |=> err_o)
      else $error("bad precision not refused");
   AST_ERR_CAUSE: assert property (err_o |-> $past(acc) && !bit_valid_o)
      else $error("error pulse without refused input");
   AST_REC_LAT: assert property (rec_valid_i |-> ##1 rec_valid_o)
      else $error("reconstruction late");
   AST_REC_LEFT: assert property (rec_valid_i && rsel == 3'h1 && rsh == 4'h0 |=> rec_sample_o == rec_sum)
      else $error("reconstruction sum wrong");
   AST_REC_HOLD: assert property (!rec_valid_o |-> $stable(rec_sample_o))
      else $error("reconstruction output moved");
   AST_DONE_READY: assert property ($fell(bit_valid_o) |-> in_ready_o)
      else $error("not ready after symbol");
   // Main scenarios: a DCT symbol, a lossless symbol, a refusal, a rebuilt sample
   COV_DCT_SYMBOL: cover property (acc && !in_mode_i ##1 bit_valid_o);
   COV_LL_SYMBOL: cover property (acc && in_mode_i ##1 bit_valid_o);
   COV_REFUSED: cover property (err_o);
   COV_REBUILT: cover property (rec_valid_o);
endmodule // jhe_coder_checker

// >>> dv/jhe_source.sv
/*
 Upstream coefficient and sample source model for the entropy coder.
 Assumes calls start at a falling clock edge; returns at a falling edge.
*/
`timescale 1ns/100ps
module jhe_source
#(
   parameter CW = 2
)
(
   input  wire          clock_i,
   input  wire          ready_i,
   output reg           valid_o,
   output reg           mode_o,
   output reg  [CW-1:0] comp_o,
   output reg           first_o,
   output reg           last_o,
   output reg  [15:0]   value_o,
   output reg  [15:0]   left_o,
   output reg  [15:0]   above_o,
   output reg  [15:0]   upleft_o
);
   initial {valid_o, mode_o, comp_o, first_o, last_o, value_o, left_o, above_o, upleft_o} = 0;
   // Hold the unit until ready is seen at a rising edge; valid stays up for back to back
   task send(input m, input [CW-1:0] c, input f, input l, input [15:0] v, a, b, u);
      begin
         valid_o = 1'b1;
         {mode_o, comp_o, first_o, last_o, value_o, left_o, above_o, upleft_o} = {m, c, f, l, v, a, b, u};
         #1;
         while (ready_i !== 1'b1) begin @(negedge clock_i); #1; end
         @(posedge clock_i);
         @(negedge clock_i);
      end
   endtask
   // Released payload shows its inverse, so stale data is never mistaken for live
   task idle;
      begin
         valid_o = 1'b0;
         {value_o, left_o, above_o, upleft_o} = ~{value_o, left_o, above_o, upleft_o};
         @(negedge clock_i);
      end
   endtask
endmodule // jhe_source

// >>> dv/jpeg_huffman_entropy_coder_test.sv
/*
 Self-checking bench of the entropy coder: tables, DCT blocks, lossless, reconstruction.
 Assumes the source model and checker files compile first.
*/
`timescale 1ns/100ps
module jpeg_huffman_entropy_coder_test;
   reg         clock_i = 1'b0, arst_n_i = 1'b0, scan_start_i = 1'b0, restart_i = 1'b0;
   reg         hierarchical_i = 1'b0, tbl_we_i = 1'b0, tbl_ac_i = 1'b0, bit_ready_i = 1'b0;
   reg  [4:0]  precision_i = 5'h0C, tbl_len_i = 5'h00;
   reg  [11:0] comp_predictor_i = 12'h249;
   reg  [15:0] comp_point_shift_i = 16'h3333, tbl_code_i = 16'h0000;
   reg  [3:0]  comp_dc_table_i = 4'h2, comp_ac_table_i = 4'h2;
   reg  [8:0]  tbl_addr_i = 9'h000;
   reg         rec_valid_i = 1'b0;
   reg  [1:0]  rec_comp_i = 2'h0;
   reg  [15:0] rec_diff_i = 16'h0000, rec_left_i = 16'h0000, rec_above_i = 16'h0000;
   reg  [15:0] rec_upleft_i = 16'h0000;
   wire        in_ready_o, in_valid_i, in_mode_i, in_first_i, in_last_i;
   wire        bit_valid_o, bit_o, err_o, rec_valid_o;
   wire [1:0]  in_comp_i;
   wire [15:0] in_value_i, in_left_i, in_above_i, in_upleft_i, rec_sample_o;
   int         mismatches = 0, n_checks = 0, seed = 32'h0e88, exp_err = 0, n_err = 0;
   int         prev[4] = '{0, 0, 0, 0};
   int         acv[63];
   logic       bq[$];
   logic [15:0] rq[$];

   jhe_entropy_coder #(.NCOMP(4), .CW(2)) u_dut (.clock_i, .arst_n_i, .scan_start_i, .restart_i,
      .hierarchical_i, .precision_i, .comp_predictor_i, .comp_point_shift_i, .comp_dc_table_i,
      .comp_ac_table_i, .tbl_we_i, .tbl_ac_i, .tbl_addr_i, .tbl_code_i, .tbl_len_i, .in_valid_i,
      .in_ready_o, .in_mode_i, .in_comp_i, .in_first_i, .in_last_i, .in_value_i, .in_left_i,
      .in_above_i, .in_upleft_i, .bit_valid_o, .bit_o, .bit_ready_i, .err_o, .rec_valid_i,
      .rec_comp_i, .rec_diff_i, .rec_left_i, .rec_above_i, .rec_upleft_i, .rec_valid_o,
      .rec_sample_o);
   jhe_source #(.CW(2)) u_src (.clock_i, .ready_i(in_ready_o), .valid_o(in_valid_i),
      .mode_o(in_mode_i), .comp_o(in_comp_i), .first_o(in_first_i), .last_o(in_last_i),
      .value_o(in_value_i), .left_o(in_left_i), .above_o(in_above_i), .upleft_o(in_upleft_i));

   initial forever #12.5 clock_i = ~clock_i;
   // The packer stalls at random so held bits are exercised
   always @(negedge clock_i) bit_ready_i <= ($random(seed) & 3) != 0;

   task chk(input string nm, input [15:0] e, input [15:0] s);
      begin
         n_checks++;
         if (s !== e) begin mismatches++; $display("Error %s expected %h seen %h", nm, e, s); end
      end
   endtask
   // Watcher: each taken bit or rebuilt sample is matched to the oldest note
   always @(posedge clock_i) begin
      if (bit_valid_o === 1'b1 && bit_ready_i) chk("bit_o", {15'h0, bq.pop_front()}, {15'h0, bit_o});
      if (rec_valid_o === 1'b1) chk("rec_sample_o", rq.pop_front(), rec_sample_o);
      if (err_o === 1'b1) n_err++;
   end

   task put(input [15:0] v, input int n);
      int i;
      for (i = n - 1; i >= 0; i--) bq.push_back(v[i]);
   endtask
   function int cat(input int v);
      int a;
      a = v < 0 ? -v : v;
      cat = 0;
      while (a != 0) begin cat++; a = a >>> 1; end
   endfunction
   // Code first, then the field: low bits of the value, or of value minus one
   task sym(input [15:0] code, input int len, input int v, input int n);
      int f;
      f = v < 0 ? v - 1 : v;
      put(code, len);
      put(f[15:0], n);
   endtask
   function int pr(input [2:0] s, input int a, input int b, input int u);
      case (s)
         3'h0: pr = 0;
         3'h1: pr = a;
         3'h2: pr = b;
         3'h3: pr = u;
         3'h4: pr = a + b - u;
         3'h5: pr = a + ((b - u) >>> 1);
         3'h6: pr = b + ((a - u) >>> 1);
         default: pr = (a + b) >>> 1;
      endcase
   endfunction
   // One block: DC difference against the same component, then AC walk
   task blk(input int c, input int dc);
      int d, r, i, k, s;
      s = comp_ac_table_i[c];
      d = dc - prev[c];
      prev[c] = dc;
      k = cat(d);
      sym({comp_dc_table_i[c], k[4:0]}, 6, d, k);
      u_src.send(1'b0, c[1:0], 1'b1, 1'b0, dc[15:0], 16'h0, 16'h0, 16'h0);
      r = 0;
      for (i = 0; i < 63; i++) begin
         k = cat(acv[i]);
         if (acv[i] != 0) begin sym({s[0], r[3:0], k[3:0]}, 9, acv[i], k); r = 0; end
         else if (i == 62) put({s[0], 8'h00}, 9);
         else begin r++; if (r == 16) begin put({s[0], 8'hF0}, 9); r = 0; end end
         u_src.send(1'b0, c[1:0], 1'b0, i == 62, acv[i][15:0], 16'h0, 16'h0, 16'h0);
      end
   endtask
   // One lossless sample: shifted, predicted, difference modulo 65536
   task ll(input int c, input [15:0] x, a, b, u);
      int s, d, k;
      reg [15:0] df;
      s = comp_point_shift_i[4*c +: 4];
      df = (x >> s) - pr(comp_predictor_i[3*c +: 3], a >> s, b >> s, u >> s);
      d = $signed(df);
      k = df == 16'h8000 ? 16 : cat(d);
      sym({comp_dc_table_i[c], k[4:0]}, 6, d, k == 16 ? 0 : k);
      u_src.send(1'b1, c[1:0], 1'b0, 1'b0, x, a, b, u);
   endtask
   task rc(input int c);
      int a, b, u, d;
      reg [15:0] e;
      {a, b, u, d} = {$random(seed) & 4095, $random(seed) & 4095, $random(seed) & 4095, $random(seed)};
      e = pr(comp_predictor_i[3*c +: 3], a, b, u) + d;
      rq.push_back(e << comp_point_shift_i[4*c +: 4]);
      {rec_valid_i, rec_comp_i, rec_diff_i, rec_left_i, rec_above_i, rec_upleft_i} =
         {1'b1, c[1:0], d[15:0], a[15:0], b[15:0], u[15:0]};
      @(negedge clock_i);
      {rec_valid_i, rec_diff_i, rec_left_i} = {1'b0, ~rec_diff_i, ~rec_left_i};
      @(negedge clock_i);
   endtask
   task drain;
      int t;
      u_src.idle;
      for (t = 0; t < 4000 && bq.size() != 0; t++) @(negedge clock_i);
      if (bq.size() != 0) mismatches++;
   endtask
   task results;
      if (mismatches == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin : main
      int i, j;
      repeat (10) @(negedge clock_i);
      arst_n_i = 1'b1;
      repeat (4) @(negedge clock_i);
      // Tables: DC code = {set, category}, AC code = {set, run, category}
      for (i = 0; i < 576; i++) begin
         {tbl_we_i, tbl_ac_i, tbl_len_i} = {1'b1, i >= 64, i >= 64 ? 5'h09 : 5'h06};
         tbl_addr_i = i >= 64 ? i - 64 : i;
         tbl_code_i = {7'h00, tbl_addr_i};
         @(negedge clock_i);
      end
      tbl_we_i = 1'b0;
      // Interleaved blocks of two components; point shift must not touch them
      for (j = 0; j < 4; j++) begin
         for (i = 0; i < 63; i++) acv[i] = ($random(seed) & 7) == 0 ? $random(seed) % 300 : 0;
         acv[62] = j == 1 ? 5 : 0;
         if (j == 2) for (i = 0; i < 63; i++) acv[i] = i == 40 ? -1 : 0;
         blk(j & 1, j * 100 - 150);
      end
      blk(0, -4045);
      u_src.send(1'b0, 2'h0, 1'b1, 1'b0, 16'h0033, 16'h0, 16'h0, 16'h0);
      exp_err++;
      drain;
      restart_i = 1'b1;
      @(negedge clock_i);
      restart_i = 1'b0;
      prev[0] = 0;
      blk(0, -7);
      drain;
      // Lossless: every selection, three components interleaved, comp 1 shifted by 2
      {scan_start_i, comp_point_shift_i} = {1'b1, 16'h0020};
      @(negedge clock_i);
      scan_start_i = 1'b0;
      for (j = 1; j < 8; j++) begin
         comp_predictor_i = {3'h7, 3'h2, j[2:0], 3'h1};
         @(negedge clock_i);
         for (i = 0; i < 3; i++) ll(i, $random(seed) & 4095, $random(seed) & 4095, $random(seed) & 4095, $random(seed) & 4095);
         u_src.idle;
         rc(1);
         rc(0);
      end
      {precision_i, comp_predictor_i[2:0]} = {5'h10, 3'h1};
      ll(0, 16'h8000, 16'h0000, 16'h1234, 16'h4321);
      ll(0, 16'hFFFF, 16'h0001, 16'h0000, 16'h0000);
      u_src.idle;
      precision_i = 5'h02;
      ll(0, 16'h0003, 16'h0000, 16'h0001, 16'h0002);
      u_src.idle;
      for (i = 0; i < 3; i++) begin
         {precision_i, comp_predictor_i[2:0]} = i == 0 ? {5'h01, 3'h1} : i == 1 ? {5'h11, 3'h1} : {5'h0C, 3'h0};
         u_src.send(1'b1, 2'h0, 1'b0, 1'b0, 16'h0005, 16'h0, 16'h0, 16'h0);
         exp_err++;
         u_src.idle;
      end
      hierarchical_i = 1'b1;
      ll(0, 16'h0123, 16'h0456, 16'h0789, 16'h0ABC);
      drain;
      repeat (4) @(negedge clock_i);
      chk("err_o count", exp_err[15:0], n_err[15:0]);
      chk("bits left", 16'h0000, bq.size());
      results;
   end
   initial begin
      #2_000_000;
      mismatches++;
      results;
   end
endmodule // jpeg_huffman_entropy_coder_test

bind jhe_entropy_coder jhe_coder_checker #(.NCOMP(NCOMP), .CW(CW)) u_chk (.clock_i, .arst_n_i,
   .hierarchical_i, .precision_i, .comp_predictor_i, .comp_point_shift_i, .in_valid_i,
   .in_ready_o, .in_mode_i, .in_comp_i, .bit_valid_o, .bit_o, .bit_ready_i, .err_o, .rec_valid_i,
   .rec_comp_i, .rec_diff_i, .rec_left_i, .rec_valid_o, .rec_sample_o);
